// ==== verilog/tcq_qualifier.sv ====
// Per-cycle event qualification by thread and privilege level with APB registers and shared counter
//
// How it works
// - Event's thread is bit 0 of controller id
// - Events classed thread-specific or thread-independent
// - Thread-specific events use only owning thread's flags
// - User flag counts user level, kernel flag kernel
// - Independent events: any thread's flag covers that level
// - Independent events with both levels covered always count
// - Clock mode counts per non-halted thread
// - Eighteen counters, any selectable for non-sleep counting
// - No-event selection keeps the counter disabled
// - Compare, threshold 15, complement counts every non-sleep clock
// - Always-true threshold overrides thread and privilege qualification
// - Non-sleep counting runs while a thread is awake
// - Power-saving only when both threads halted; counting stops
// - Two threads; either may halt independently
// - Both threads of a core share one counter set
// - User flags qualify levels 1-3, kernel level 0
// - Complement counts at or below threshold, else above
// - Counter enable cleared by reset
`default_nettype none
module tcq_qualifier #(
  parameter int NUM_COUNTERS = tcq_pkg::NUM_COUNTERS_DEF // Counters in the shared set
) (
  input wire logic pclk, // APB clock, 100 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [3:0] event_count, // Raw events detected this cycle
  input wire logic thread_independent_class, // High when the event has no owning thread
  input wire logic [7:0] initial_interrupt_controller_id, // Id of the thread raising the event
  input wire logic [1:0] thread0_cpl, // Thread 0 current privilege level
  input wire logic [1:0] thread1_cpl, // Thread 1 current privilege level
  input wire logic thread0_halted, // Thread 0 halted
  input wire logic thread1_halted, // Thread 1 halted
  output logic [NUM_COUNTERS-1:0] count_enable, // One-hot count enable to the selected counter
  output logic power_saving // Package in power-saving state
);

  // Register state
  logic [31:0] evsel_q; // Event selection control
  logic [31:0] cntcfg_q; // Counter configuration control
  logic [31:0] count_q; // Shared counter
  logic [3:0] inc_q; // Amount delivered last cycle
  logic [NUM_COUNTERS-1:0] count_enable_q; // Registered count enable
  logic sleep_q; // Registered power-saving state
  logic [31:0] prdata_q; // Registered read data
  logic pready_q; // Registered ready
  logic pslverr_q; // Registered error

  // Decoded fields
  logic thread0_user_enable; // Thread 0 user flag
  logic thread0_kernel_enable; // Thread 0 kernel flag
  logic thread1_user_enable; // Thread 1 user flag
  logic thread1_kernel_enable; // Thread 1 kernel flag
  logic [5:0] ev_select; // Event select field
  logic running_mask; // Running sub-event chosen
  logic cfg_enable; // Counter enable
  logic cfg_compare; // Compare filter on
  logic cfg_complement; // Complement compare
  logic [3:0] cfg_threshold; // Threshold value
  logic [4:0] cfg_csel; // Selected counter

  // Qualification terms
  logic clock_mode; // Non-halted clock counting selected
  logic sleep_c; // Both threads halted this cycle
  logic always_true; // Threshold condition true every cycle
  logic ts_thread; // Owning thread of a thread-specific event
  logic ts_qual; // Thread-specific qualification
  logic ti_qual; // Thread-independent qualification
  logic [3:0] raw_c; // Qualified raw count
  logic [3:0] inc_d; // Amount delivered this cycle
  logic allowed; // Enable, selection and wake state
  logic wr_en; // APB write takes effect
  logic rd_hit; // Address is mapped

  // Privilege match of one thread: kernel flag at level 0, user flag otherwise
  function automatic logic level_match(input logic user_f, input logic kernel_f, input logic [1:0] current_privilege_level);
    level_match = (current_privilege_level == tcq_pkg::CPL_KERNEL) ? kernel_f : user_f;
  endfunction

  // Field decode
  assign thread0_user_enable = evsel_q[tcq_pkg::THREAD0_USER_BIT];
  assign thread0_kernel_enable = evsel_q[tcq_pkg::THREAD0_KERNEL_BIT];
  assign thread1_user_enable = evsel_q[tcq_pkg::THREAD1_USER_BIT];
  assign thread1_kernel_enable = evsel_q[tcq_pkg::THREAD1_KERNEL_BIT];
  assign ev_select = evsel_q[tcq_pkg::SEL_MSB:tcq_pkg::SEL_LSB];
  assign running_mask = evsel_q[tcq_pkg::RUNNING_MASK_BIT];
  assign cfg_enable = cntcfg_q[tcq_pkg::ENABLE_BIT];
  assign cfg_compare = cntcfg_q[tcq_pkg::COMPARE_BIT];
  assign cfg_complement = cntcfg_q[tcq_pkg::COMPLEMENT_BIT];
  assign cfg_threshold = cntcfg_q[tcq_pkg::THR_MSB:tcq_pkg::THR_LSB];
  assign cfg_csel = cntcfg_q[tcq_pkg::CSEL_MSB:tcq_pkg::CSEL_LSB];

  // Qualification of this cycle's event, from the thread state sampled this clock
  always_comb begin
    clock_mode = (ev_select == tcq_pkg::SEL_POWER_EVENTS) && running_mask;
    sleep_c = thread0_halted && thread1_halted;
    always_true = cfg_compare && cfg_complement && (cfg_threshold == tcq_pkg::THR_ALWAYS);
    ts_thread = initial_interrupt_controller_id[0];
    // Only the owning thread's flags matter
    if (ts_thread) begin
      ts_qual = level_match(thread1_user_enable, thread1_kernel_enable, thread1_cpl);
    end else begin
      ts_qual = level_match(thread0_user_enable, thread0_kernel_enable, thread0_cpl);
    end
    // Either thread's flag opens its level; both levels covered counts always
    if ((thread0_user_enable || thread1_user_enable) && (thread0_kernel_enable || thread1_kernel_enable)) begin
      ti_qual = 1'b1;
    end else begin
      ti_qual = ((thread0_user_enable || thread1_user_enable)
                 && (thread0_cpl != tcq_pkg::CPL_KERNEL || thread1_cpl != tcq_pkg::CPL_KERNEL))
             || ((thread0_kernel_enable || thread1_kernel_enable)
                 && (thread0_cpl == tcq_pkg::CPL_KERNEL || thread1_cpl == tcq_pkg::CPL_KERNEL));
    end
    // Raw count by mode
    if (clock_mode) begin
      // One clock per awake thread whose own flags match its level
      raw_c = {3'h0, !thread0_halted
                     && level_match(thread0_user_enable, thread0_kernel_enable, thread0_cpl)}
            + {3'h0, !thread1_halted
                     && level_match(thread1_user_enable, thread1_kernel_enable, thread1_cpl)};
    end else if (thread_independent_class) begin
      raw_c = ti_qual ? event_count : 4'h0;
    end else begin
      raw_c = ts_qual ? event_count : 4'h0;
    end
    // Enable, a real event selection and an awake package
    allowed = cfg_enable && (ev_select != tcq_pkg::SEL_NO_EVENT) && !sleep_c;
    // Filter stage
    if (!allowed) begin
      inc_d = 4'h0;
    end else if (always_true) begin
      inc_d = 4'h1;
    end else if (cfg_compare) begin
      if (cfg_complement) begin
        inc_d = {3'h0, raw_c <= cfg_threshold};
      end else begin
        inc_d = {3'h0, raw_c > cfg_threshold};
      end
    end else begin
      inc_d = raw_c;
    end
  end

  // APB decode
  assign wr_en = psel && penable && pwrite && pready_q;
  assign rd_hit = (paddr == tcq_pkg::ADDR_EVSEL) || (paddr == tcq_pkg::ADDR_CNTCFG)
               || (paddr == tcq_pkg::ADDR_STATUS) || (paddr == tcq_pkg::ADDR_COUNT);

  // Event selection register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evsel_q <= tcq_pkg::EVSEL_RESET;
    end else if (wr_en && paddr == tcq_pkg::ADDR_EVSEL) begin
      evsel_q <= pwdata;
    end
  end

  // Counter configuration register, enable clear after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cntcfg_q <= tcq_pkg::CNTCFG_RESET;
    end else if (wr_en && paddr == tcq_pkg::ADDR_CNTCFG) begin
      cntcfg_q <= pwdata;
    end
  end

  // Shared counter: software write wins over the increment of that cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 32'h00000000;
    end else if (wr_en && paddr == tcq_pkg::ADDR_COUNT) begin
      count_q <= pwdata;
    end else begin
      count_q <= count_q + {28'h0000000, inc_d};
    end
  end

  // Count enable to the selected counter, one cycle after sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_enable_q <= '0;
      inc_q <= 4'h0;
      sleep_q <= 1'b0;
    end else begin
      inc_q <= inc_d;
      sleep_q <= sleep_c;
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        count_enable_q[i] <= (inc_d != 4'h0) && (32'(cfg_csel) == i);
      end
    end
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !rd_hit;
      prdata_q <= 32'h00000000;
      if (psel && penable && !pready_q && !pwrite) begin
        case (paddr)
          tcq_pkg::ADDR_EVSEL: begin
            prdata_q <= evsel_q;
          end
          tcq_pkg::ADDR_CNTCFG: begin
            prdata_q <= cntcfg_q;
          end
          tcq_pkg::ADDR_STATUS: begin
            prdata_q[tcq_pkg::ST_HALT0_BIT] <= thread0_halted;
            prdata_q[tcq_pkg::ST_HALT1_BIT] <= thread1_halted;
            prdata_q[tcq_pkg::ST_SLEEP_BIT] <= sleep_q;
            prdata_q[tcq_pkg::ST_COUNT_BIT] <= (inc_q != 4'h0);
          end
          tcq_pkg::ADDR_COUNT: begin
            prdata_q <= count_q;
          end
          default: begin
            prdata_q <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign count_enable = count_enable_q;
  assign power_saving = sleep_q;

  // Checks on the qualification
  logic filt_off; // No compare filter active
  assign filt_off = !cfg_compare;

  property p_reset_enable;
    @(posedge pclk) disable iff (!presetn) !cfg_enable |=> inc_q == 4'h0 && count_enable_q == '0;
  endproperty
  a_reset_enable: assert property (p_reset_enable) else $error("Counted while disabled");

  property p_sleep_stop;
    @(posedge pclk) disable iff (!presetn) thread0_halted && thread1_halted |=> inc_q == 4'h0 && sleep_q;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("Counted in power-saving state");

  property p_always_true;
    @(posedge pclk) disable iff (!presetn)
      always_true && cfg_enable && ev_select != tcq_pkg::SEL_NO_EVENT && !sleep_c |=> inc_q == 4'h1;
  endproperty
  a_always_true: assert property (p_always_true) else $error("Always-true threshold missed a clock");

  property p_override;
    @(posedge pclk) disable iff (!presetn)
      always_true && cfg_enable && ev_select != tcq_pkg::SEL_NO_EVENT && evsel_q[3:0] == 4'h0
      && (!thread0_halted || !thread1_halted) |=> count_enable_q != '0 || cfg_csel >= NUM_COUNTERS;
  endproperty
  a_override: assert property (p_override) else $error("Qualification gated an always-true count");

  property p_no_event;
    @(posedge pclk) disable iff (!presetn) ev_select == tcq_pkg::SEL_NO_EVENT |=> inc_q == 4'h0;
  endproperty
  a_no_event: assert property (p_no_event) else $error("Counted with no event selected");

  property p_ts_own_flags;
    @(posedge pclk) disable iff (!presetn)
      cfg_enable && filt_off && !clock_mode && !thread_independent_class && !initial_interrupt_controller_id[0]
      && !thread0_user_enable && !thread0_kernel_enable |=> inc_q == 4'h0;
  endproperty
  a_ts_own_flags: assert property (p_ts_own_flags) else $error("Other thread flags counted event");

  property p_ts_thread1;
    @(posedge pclk) disable iff (!presetn)
      cfg_enable && filt_off && !clock_mode && !sleep_c && ev_select != tcq_pkg::SEL_NO_EVENT
      && !thread_independent_class && initial_interrupt_controller_id[0]
      && thread1_user_enable && thread1_kernel_enable |=> inc_q == $past(event_count);
  endproperty
  a_ts_thread1: assert property (p_ts_thread1) else $error("Thread 1 event not counted");

  property p_ti_zero;
    @(posedge pclk) disable iff (!presetn)
      filt_off && !clock_mode && thread_independent_class && evsel_q[3:0] == 4'h0 |=> inc_q == 4'h0;
  endproperty
  a_ti_zero: assert property (p_ti_zero) else $error("Independent event counted with flags clear");

  property p_ti_cover;
    @(posedge pclk) disable iff (!presetn)
      cfg_enable && filt_off && !clock_mode && !sleep_c && ev_select != tcq_pkg::SEL_NO_EVENT
      && thread_independent_class && thread0_user_enable && thread1_kernel_enable
      |=> inc_q == $past(event_count);
  endproperty
  a_ti_cover: assert property (p_ti_cover) else $error("Covered independent event not counted");

  property p_clock_one;
    @(posedge pclk) disable iff (!presetn)
      cfg_enable && filt_off && clock_mode && thread0_halted && !thread1_halted
      && thread1_user_enable && thread1_kernel_enable
      |=> inc_q == 4'h1
      && (count_q == $past(count_q) + 32'h1 || $past(wr_en && paddr == tcq_pkg::ADDR_COUNT));
  endproperty
  a_clock_one: assert property (p_clock_one) else $error("Non-halted clock not counted once");

  // Both awake threads with every flag set give two clocks in one cycle
  property p_clock_two;
    @(posedge pclk) disable iff (!presetn)
      cfg_enable && filt_off && clock_mode && !thread0_halted && !thread1_halted
      && thread0_user_enable && thread0_kernel_enable
      && thread1_user_enable && thread1_kernel_enable |=> inc_q == 4'h2;
  endproperty
  a_clock_two: assert property (p_clock_two) else $error("Awake threads not counted per thread");

  // Compare filter outside the always-true setup delivers one count or none
  property p_filter;
    @(posedge pclk) disable iff (!presetn)
      cfg_enable && cfg_compare && !always_true && ev_select != tcq_pkg::SEL_NO_EVENT && !sleep_c
      |=> inc_q == {3'h0, $past(cfg_complement) ? ($past(raw_c) <= $past(cfg_threshold))
                                                : ($past(raw_c) > $past(cfg_threshold))};
  endproperty
  a_filter: assert property (p_filter) else $error("Threshold compare delivered a wrong count");

  // At most one counter sees the enable, and only when something is delivered
  property p_one_hot;
    @(posedge pclk) disable iff (!presetn) $onehot0(count_enable_q) && (count_enable_q == '0 || inc_q != 4'h0);
  endproperty
  a_one_hot: assert property (p_one_hot) else $error("Count enable not one-hot to a counting cycle");

  // A software write to the shared counter lands whole
  property p_count_write;
    @(posedge pclk) disable iff (!presetn) wr_en && paddr == tcq_pkg::ADDR_COUNT |=> count_q == $past(pwdata);
  endproperty
  a_count_write: assert property (p_count_write) else $error("Shared counter write lost");

  c_non_sleep: cover property (@(posedge pclk) disable iff (!presetn) always_true && inc_d == 4'h1);
  c_sleep: cover property (@(posedge pclk) disable iff (!presetn) cfg_enable && sleep_c ##1 !sleep_c);
  c_ti_count: cover property (@(posedge pclk) disable iff (!presetn) thread_independent_class && inc_d != 4'h0);
  c_both_clock: cover property (@(posedge pclk) disable iff (!presetn) clock_mode && inc_d == 4'h2);
  c_filter_one: cover property (@(posedge pclk) disable iff (!presetn) cfg_compare && !always_true && inc_d == 4'h1);

endmodule
`default_nettype wire

// ==== verilog/tcq_pkg.sv ====
// Package with register map, field positions and codes for the thread event qualifier
`default_nettype none
package tcq_pkg;
  // APB byte addresses of the registers
  localparam logic [7:0] ADDR_EVSEL = 8'h00; // Event selection control
  localparam logic [7:0] ADDR_CNTCFG = 8'h04; // Counter configuration control
  localparam logic [7:0] ADDR_STATUS = 8'h08; // Thread and counting status
  localparam logic [7:0] ADDR_COUNT = 8'h0C; // Shared event counter value
  // Event selection control fields
  localparam int THREAD1_USER_BIT = 0; // Thread 1 user-level flag
  localparam int THREAD1_KERNEL_BIT = 1; // Thread 1 kernel-level flag
  localparam int THREAD0_USER_BIT = 2; // Thread 0 user-level flag
  localparam int THREAD0_KERNEL_BIT = 3; // Thread 0 kernel-level flag
  localparam int MASK_LSB = 9; // Event mask low bit
  localparam int MASK_MSB = 24; // Event mask high bit
  localparam int SEL_LSB = 25; // Event select low bit
  localparam int SEL_MSB = 30; // Event select high bit
  localparam int RUNNING_MASK_BIT = 9; // Running sub-event of the power events
  // Counter configuration control fields
  localparam int CSEL_LSB = 0; // Counter select low bit
  localparam int CSEL_MSB = 4; // Counter select high bit
  localparam int ENABLE_BIT = 12; // Counter enable
  localparam int COMPARE_BIT = 18; // Threshold compare filter on
  localparam int COMPLEMENT_BIT = 19; // Less-or-equal compare
  localparam int THR_LSB = 20; // Threshold low bit
  localparam int THR_MSB = 23; // Threshold high bit
  // Status fields
  localparam int ST_HALT0_BIT = 0; // Thread 0 halted
  localparam int ST_HALT1_BIT = 1; // Thread 1 halted
  localparam int ST_SLEEP_BIT = 2; // Package in power-saving state
  localparam int ST_COUNT_BIT = 3; // Count delivered last cycle
  // Codes and constants
  localparam logic [5:0] SEL_NO_EVENT = 6'h00; // No event selected
  localparam logic [5:0] SEL_POWER_EVENTS = 6'h01; // Power events class (value arbitrary)
  localparam logic [3:0] THR_ALWAYS = 4'hF; // Threshold no event can exceed
  localparam logic [1:0] CPL_KERNEL = 2'h0; // Most privileged level
  localparam logic [31:0] EVSEL_RESET = 32'h00000000; // Event selection reset value
  localparam logic [31:0] CNTCFG_RESET = 32'h00000000; // Enable clear after reset
  localparam int NUM_COUNTERS_DEF = 18; // Counters sharing the qualifier
endpackage
`default_nettype wire

// ==== verif/tcq_event_source.sv ====
// Behavioural model of the pipeline event sources and the thread halt state
`default_nettype none
module tcq_event_source (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic active, // Random thread activity when high
  input wire logic [1:0] hold_halt, // Halt state held while quiet
  output logic [3:0] ev_cnt, // Raw events this cycle
  output logic ti_cls, // Event has no owning thread
  output logic [7:0] ic_id, // Controller id of the raising thread
  output logic [1:0] cpl0, // Thread 0 privilege level
  output logic [1:0] cpl1, // Thread 1 privilege level
  output logic halt0, // Thread 0 halted
  output logic halt1 // Thread 1 halted
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] h; // Halt draw of this cycle

  // New thread state and events after every edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ev_cnt, ti_cls, ic_id, cpl0, cpl1, halt0, halt1} <= '0;
    end else if (active) begin
      h = 2'($urandom);
      halt0 <= h[0];
      halt1 <= h[1];
      cpl0 <= 2'($urandom);
      cpl1 <= 2'($urandom);
      ti_cls <= 1'($urandom);
      // Only an awake thread raises an event
      ic_id <= {7'($urandom), h[0] | (!h[1] & 1'($urandom))};
      // Nothing is detected while both threads sleep
      ev_cnt <= (&h) ? 4'h0 : 4'($urandom);
    end else begin
      halt0 <= hold_halt[0];
      halt1 <= hold_halt[1];
      ev_cnt <= 4'h0;
      cpl0 <= 2'h0;
      cpl1 <= 2'h0;
      ti_cls <= 1'b0;
      // Unused id keeps changing so it is never trusted
      ic_id <= ~ic_id;
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking testbench of the thread event qualifier
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NC = 18; // Counters in the shared set
  logic pclk = 1'b0; // Core clock
  logic presetn, psel, penable, pwrite, pready, pslverr, ti_cls, halt0, halt1, active, power_saving;
  logic [7:0] paddr, ic_id; // Address and controller id
  logic [31:0] pwdata, prdata, evsel_sh, cfg_sh; // Bus data and register shadows
  logic [3:0] ev_cnt; // Raw events
  logic [1:0] cpl0, cpl1, hold_halt; // Privilege levels and quiet halt state
  logic [NC-1:0] count_enable; // Count enables
  logic [NC:0] exp_q[$]; // Expected power_saving and count enables
  logic [32:0] apb_q[$]; // Expected pslverr and read data
  logic [NC:0] e; // Oldest qualifier note
  logic [32:0] a; // Oldest bus note
  int mismatches = 0;
  int num_checks = 0;

  always #5 pclk = ~pclk;

  tcq_qualifier #(.NUM_COUNTERS(NC)) tcq_qualifier_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_count(ev_cnt), .thread_independent_class(ti_cls),
    .initial_interrupt_controller_id(ic_id), .thread0_cpl(cpl0), .thread1_cpl(cpl1), .thread0_halted(halt0),
    .thread1_halted(halt1), .count_enable(count_enable), .power_saving(power_saving));

  tcq_event_source tcq_event_source_i (.pclk(pclk), .presetn(presetn), .active(active), .hold_halt(hold_halt),
    .ev_cnt(ev_cnt), .ti_cls(ti_cls), .ic_id(ic_id), .cpl0(cpl0), .cpl1(cpl1), .halt0(halt0), .halt1(halt1));

  // Compare one value and count the result
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Expected outputs for the coming edge from the shadows and thread state
  function automatic logic [NC:0] expect_out();
    logic u0, u1, ok0, ok1, hit;
    int amt;
    u0 = (cpl0 != tcq_pkg::CPL_KERNEL);
    u1 = (cpl1 != tcq_pkg::CPL_KERNEL);
    ok0 = u0 ? evsel_sh[2] : evsel_sh[3];
    ok1 = u1 ? evsel_sh[0] : evsel_sh[1];
    if (evsel_sh[30:25] == tcq_pkg::SEL_POWER_EVENTS && evsel_sh[9]) begin
      amt = int'(!halt0 && ok0) + int'(!halt1 && ok1);
    end else if (ti_cls) begin
      amt = (((evsel_sh[0] | evsel_sh[2]) && (u0 | u1)) || ((evsel_sh[1] | evsel_sh[3]) && !(u0 & u1)))
        ? int'(ev_cnt) : 0;
    end else begin
      amt = (ic_id[0] ? ok1 : ok0) ? int'(ev_cnt) : 0;
    end
    hit = cfg_sh[18] ? (cfg_sh[19] ? amt <= int'(cfg_sh[23:20]) : amt > int'(cfg_sh[23:20])) : amt != 0;
    if (cfg_sh[18] && cfg_sh[19] && cfg_sh[23:20] == tcq_pkg::THR_ALWAYS) begin
      hit = 1'b1;
    end
    if (!cfg_sh[12] || evsel_sh[30:25] == tcq_pkg::SEL_NO_EVENT || (halt0 && halt1)) begin
      hit = 1'b0;
    end
    return {halt0 & halt1, (hit && cfg_sh[4:0] < 5'd18) ? NC'(1) << cfg_sh[4:0] : NC'(0)};
  endfunction

  // Note what the next edge must deliver
  always @(negedge pclk) begin
    if (presetn === 1'b1) begin
      exp_q.push_back(expect_out());
    end
  end

  // Compare the registered outputs once they have settled
  always @(posedge pclk) begin
    #1;
    if (presetn !== 1'b1) begin
      exp_q.delete();
    end else if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check("count_enable", 32'(count_enable), 32'(e[NC-1:0]));
      check("power_saving", 32'(power_saving), 32'(e[NC]));
    end
  end

  // Compare each bus answer with its note
  always @(negedge pclk) begin
    if (pready === 1'b1) begin
      a = apb_q.size() > 0 ? apb_q.pop_front() : 33'h1FFFFFFFF;
      check("prdata", prdata, a[31:0]);
      check("pslverr", 32'(pslverr), 32'(a[32]));
    end
  end

  // One bus transfer, held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d, input logic [31:0] rd,
    input logic err);
    int n;
    apb_q.push_back({err, rd});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      check("pready", 32'(pready), 32'h1);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (wr && !err && ad == tcq_pkg::ADDR_EVSEL) begin
      evsel_sh = d;
    end
    if (wr && !err && ad == tcq_pkg::ADDR_CNTCFG) begin
      cfg_sh = d;
    end
  endtask

  // Register write that must be accepted
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 32'h0, 1'b0);
  endtask

  // Main sequence
  initial begin
    logic [31:0] d;
    void'($urandom(32'h1908E277));
    {presetn, psel, penable, pwrite, active, paddr, pwdata, hold_halt, evsel_sh, cfg_sh} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, tcq_pkg::ADDR_EVSEL, 32'h0, tcq_pkg::EVSEL_RESET, 1'b0);
    apb(1'b0, tcq_pkg::ADDR_CNTCFG, 32'h0, tcq_pkg::CNTCFG_RESET, 1'b0);
    active <= 1'b1;
    wr(tcq_pkg::ADDR_CNTCFG, 32'h0000_1000 | 32'($urandom_range(17)));
    // Every flag setting, event mode then clock mode
    for (int f = 0; f < 16; f++) begin
      for (int m = 0; m < 2; m++) begin
        wr(tcq_pkg::ADDR_EVSEL, m ? {1'b0, tcq_pkg::SEL_POWER_EVENTS, 16'h0001, 5'h00, 4'(f)}
          : {1'b0, 6'h02, 21'h0, 4'(f)});
        repeat (25) @(posedge pclk);
      end
    end
    // Always-true threshold counts every awake cycle
    wr(tcq_pkg::ADDR_EVSEL, 32'h0400_0000);
    wr(tcq_pkg::ADDR_CNTCFG, 32'h00FC_1011);
    repeat (60) @(posedge pclk);
    // No-event selection leaves the counter idle
    wr(tcq_pkg::ADDR_EVSEL, 32'h0000_000F);
    repeat (30) @(posedge pclk);
    // Compare filter with random thresholds, both senses
    wr(tcq_pkg::ADDR_EVSEL, 32'h0400_000F);
    for (int k = 0; k < 6; k++) begin
      wr(tcq_pkg::ADDR_CNTCFG, {8'h00, 4'($urandom), 1'(k), 1'b1, 5'h00, 1'b1, 7'h00, 5'h00});
      repeat (30) @(posedge pclk);
    end
    // Counter select beyond the last counter
    wr(tcq_pkg::ADDR_CNTCFG, 32'h0000_1012);
    repeat (20) @(posedge pclk);
    // Quiet threads, both halted, counter disabled
    active <= 1'b0;
    hold_halt <= 2'b11;
    wr(tcq_pkg::ADDR_CNTCFG, 32'h0);
    d = $urandom;
    wr(tcq_pkg::ADDR_COUNT, d);
    apb(1'b0, tcq_pkg::ADDR_COUNT, 32'h0, d, 1'b0);
    apb(1'b1, tcq_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 32'h0, 1'b0);
    apb(1'b0, tcq_pkg::ADDR_STATUS, 32'h0, 32'h0000_0007, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h10, d, 32'h0, 1'b1);
    // Second reset in mid-run clears the enable
    wr(tcq_pkg::ADDR_CNTCFG, 32'h0000_1000);
    presetn <= 1'b0;
    evsel_sh = 32'h0;
    cfg_sh = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, tcq_pkg::ADDR_CNTCFG, 32'h0, tcq_pkg::CNTCFG_RESET, 1'b0);
    repeat (5) @(posedge pclk);
    end_of_test();
  end

  // Watchdog against a hang
  initial begin
    #100us;
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
